// ==== hw/pfhw_ctrl.sv ====
// Flag input, video and shift clocks, pixel capture and host width control
// Function
// - Control bit 3 low, bit 2 high enables split transfer on the flag input.
// - Split mode: flag rising during blanking produces one extra shift clock cycle.
// - Control bit 3 high, bit 2 low: nibble mode, flag sampled at video clock fall.
// - Nibble mode: sampled flag high selects upper nibble at next shift clock rise.
// - Both control bits low: flag input ignored completely.
// - Drive a programmable video clock output for graphics processor synchronisation.
// - Pass-through pixel bus can be chosen as pixel source.
// - Pass-through source uses no multiplexing, one byte per pixel.
// - Write data captured on the rising edge of the write strobe.
// - Width select high: 8-bit host transfers, bit 7 most significant.
// - 6-bit mode still keeps the full 8-bit value in the palette.
// - 6-bit mode: bits 5..0 move to 7..2, two low bits zero to DAC.
// - 6-bit mode: holding register reads return zero in the two top bits.
// - Shift clock held inactive in blanking except for the split extra pulse; derived by dividing the dot clock.
`default_nettype none
module pfhw_ctrl #(
    parameter int DEPTH = pfhw_pkg::PIX_BUF_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [pfhw_pkg::BYTE_W-1:0] gen_ctrl,
    input wire logic blank,
    input wire logic passthrough_en,
    input wire logic [pfhw_pkg::DIV_W-1:0] video_clock_out_div,
    input wire logic [pfhw_pkg::DIV_W-1:0] sclk_div,
    input wire logic split_or_nibble_flag_in,
    input wire logic [pfhw_pkg::BYTE_W-1:0] pixel_bus_in,
    input wire logic [pfhw_pkg::BYTE_W-1:0] passthrough_pixel_bus,
    input wire logic host_wr_n,
    input wire logic [pfhw_pkg::BYTE_W-1:0] host_data_in,
    input wire logic width8_sel,
    input wire logic [pfhw_pkg::BYTE_W-1:0] palette_hold_in,
    input wire logic [pfhw_pkg::BYTE_W-1:0] palette_dac_in,
    input wire logic pix_ready,
    output logic video_clock_out,
    output logic shift_clock_out,
    output var pfhw_pkg::pfhw_host_wr_t host_wr,
    output logic [pfhw_pkg::BYTE_W-1:0] host_rd_data,
    output logic [pfhw_pkg::BYTE_W-1:0] dac_data,
    output var pfhw_pkg::pfhw_pixel_t pix_out,
    output logic pix_valid
);
    import pfhw_pkg::*;

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic flag_s1_reg, flag_s2_reg, flag_d_reg;
    logic wr_s1_reg, wr_s2_reg, wr_d_reg;
    logic w8_s1_reg, w8_s2_reg;
    logic [BYTE_W-1:0] pix_s1_reg, pix_s2_reg;
    logic [BYTE_W-1:0] pass_s1_reg, pass_s2_reg;
    logic [BYTE_W-1:0] hd_s1_reg, hd_s2_reg;

    // Flag, strobe, width select and pixel/data pins pass two flops; flag and strobe add a third for edge detection
    always_ff @(posedge clk) begin
        if (reset) begin
            {flag_s1_reg, flag_s2_reg, flag_d_reg} <= {3{1'b0}};
            {wr_s1_reg, wr_s2_reg, wr_d_reg} <= {3{1'b1}};
            {w8_s1_reg, w8_s2_reg} <= {2{1'b1}};
            {pix_s1_reg, pix_s2_reg, pass_s1_reg, pass_s2_reg} <= {4{BYTE_ZERO}};
            {hd_s1_reg, hd_s2_reg} <= {2{BYTE_ZERO}};
        end else begin
            flag_s1_reg <= split_or_nibble_flag_in;
            flag_s2_reg <= flag_s1_reg;
            flag_d_reg <= flag_s2_reg;
            {wr_d_reg, wr_s2_reg, wr_s1_reg} <= {wr_s2_reg, wr_s1_reg, host_wr_n};
            {w8_s2_reg, w8_s1_reg} <= {w8_s1_reg, width8_sel};
            {pix_s2_reg, pix_s1_reg} <= {pix_s1_reg, pixel_bus_in};
            {pass_s2_reg, pass_s1_reg} <= {pass_s1_reg, passthrough_pixel_bus};
            {hd_s2_reg, hd_s1_reg} <= {hd_s1_reg, host_data_in};
        end
    end

    // ****************************************
    // Flag role decode
    // ****************************************
    pfhw_flag_mode_t mode;
    logic flag_rise;
    // Both bits high is left as its own code and acts like ignore
    always_comb begin
        case ({gen_ctrl[GC_NIBBLE_BIT], gen_ctrl[GC_SPLIT_BIT]})
            2'b01: mode = FLAG_SPLIT;
            2'b10: mode = FLAG_NIBBLE;
            2'b11: mode = FLAG_ILLEGAL;
            default: mode = FLAG_IGNORE;
        endcase
    end

    assign flag_rise = flag_s2_reg & ~flag_d_reg;

    // ****************************************
    // Video clock divider
    // ****************************************
    logic [DIV_W-1:0] vcnt_reg;
    logic video_clock_out_reg;
    logic video_clock_out_term, video_clock_out_fall;
    assign video_clock_out_term = (vcnt_reg == video_clock_out_div);
    assign video_clock_out_fall = video_clock_out_term & video_clock_out_reg;
    assign video_clock_out = video_clock_out_reg;
    // Half period is video_clock_out_div + 1 dot clocks
    always_ff @(posedge clk) begin
        if (reset) begin
            vcnt_reg <= DIV_ZERO;
            video_clock_out_reg <= 1'b0;
        end else if (video_clock_out_term) begin
            vcnt_reg <= DIV_ZERO;
            video_clock_out_reg <= ~video_clock_out_reg;
        end else begin
            vcnt_reg <= vcnt_reg + 1'b1;
        end
    end

    // ****************************************
    // Nibble flag sample
    // ****************************************
    logic nib_flag_reg;
    // Sampled on the video clock's falling edge, held until the next one
    always_ff @(posedge clk) begin
        if (reset) begin
            nib_flag_reg <= 1'b0;
        end else if (mode != FLAG_NIBBLE) begin
            nib_flag_reg <= 1'b0;
        end else if (video_clock_out_fall) begin
            nib_flag_reg <= flag_s2_reg;
        end
    end

    // ****************************************
    // Split transfer request
    // ****************************************
    logic extra_pend_reg;
    pfhw_sc_state_t sc_state_reg;
    logic extra_take;
    assign extra_take = (sc_state_reg == SC_LOW) & blank & extra_pend_reg;
    // A new rise wins over the clear; ending the blank drops the request
    always_ff @(posedge clk) begin
        if (reset) begin
            extra_pend_reg <= 1'b0;
        end else if (mode == FLAG_SPLIT && blank && flag_rise) begin
            extra_pend_reg <= 1'b1;
        end else if (extra_take || !blank) begin
            extra_pend_reg <= 1'b0;
        end
    end

    // ****************************************
    // Shift clock generator
    // ****************************************
    logic [DIV_W-1:0] scnt_reg;
    logic sc_term, buf_in_ready, push;
    assign sc_term = (scnt_reg == sclk_div);
    assign shift_clock_out = (sc_state_reg != SC_LOW);
    // A full buffer holds the clock low, so the VRAM is not shifted past a word
    assign push = (sc_state_reg == SC_LOW) & ~blank & sc_term & buf_in_ready;
    // Normal cycles only outside blanking; the extra pulse is not a pixel
    always_ff @(posedge clk) begin
        if (reset) begin
            sc_state_reg <= SC_LOW;
            scnt_reg <= DIV_ZERO;
        end else begin
            case (sc_state_reg)
                SC_LOW: begin
                    if (extra_take) begin
                        sc_state_reg <= SC_EXTRA;
                        scnt_reg <= DIV_ZERO;
                    end else if (blank) begin
                        scnt_reg <= DIV_ZERO;
                    end else if (push) begin
                        sc_state_reg <= SC_HIGH;
                        scnt_reg <= DIV_ZERO;
                    end else if (!sc_term) begin
                        scnt_reg <= scnt_reg + 1'b1;
                    end
                end
                default: begin
                    // Blanking cuts a normal high phase short; the extra pulse runs its length
                    if (sc_term || (blank && sc_state_reg == SC_HIGH)) begin
                        sc_state_reg <= SC_LOW;
                        scnt_reg <= DIV_ZERO;
                    end else begin
                        scnt_reg <= scnt_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Pixel select and two-entry buffer
    // ****************************************
    pfhw_pixel_t buf_in;
    pfhw_pixel_t mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;
    logic [CW-1:0] cnt_reg;
    logic pop;
    // Pass-through takes one whole byte; nibble mode picks one half
    always_comb begin
        buf_in.passthru = passthrough_en;
        buf_in.upper_nib = 1'b0;
        buf_in.data = pix_s2_reg;
        if (passthrough_en) begin
            buf_in.data = pass_s2_reg;
        end else if (mode == FLAG_NIBBLE && nib_flag_reg) begin
            buf_in.upper_nib = 1'b1;
            buf_in.data = {NIB_PAD, pix_s2_reg[NIB_HI_MSB:NIB_HI_LSB]};
        end else if (mode == FLAG_NIBBLE) begin
            buf_in.data = {NIB_PAD, pix_s2_reg[NIB_LO_MSB:0]};
        end
    end

    assign buf_in_ready = (cnt_reg != CNT_FULL);
    assign pix_valid = (cnt_reg != '0);
    assign pop = pix_valid & pix_ready;
    assign pix_out = mem_reg[rd_ptr_reg];
    // Storage written only on a push
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= buf_in;
        end
    end

    // Pointers wrap at the depth
    always_ff @(posedge clk) begin
        if (reset) begin
            {wr_ptr_reg, rd_ptr_reg, cnt_reg} <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + PTR_ONE;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + PTR_ONE;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + CNT_ONE;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - CNT_ONE;
            end
        end
    end

    // ****************************************
    // Host write capture and width handling
    // ****************************************
    logic wr_rise;
    // Data pins must hold past the strobe's rise by one dot clock
    assign wr_rise = wr_s2_reg & ~wr_d_reg;
    // Stored byte is never trimmed, whatever the width select says
    always_ff @(posedge clk) begin
        if (reset) begin
            host_wr <= '0;
        end else begin
            host_wr.strobe <= wr_rise;
            if (wr_rise) begin
                host_wr.data <= hd_s2_reg;
            end
        end
    end

    // Output mux to the DAC and holding register read path
    always_ff @(posedge clk) begin
        if (reset) begin
            {dac_data, host_rd_data} <= {2{BYTE_ZERO}};
        end else if (w8_s2_reg) begin
            dac_data <= palette_dac_in;
            host_rd_data <= palette_hold_in;
        end else begin
            dac_data <= {palette_dac_in[SIX_MSB:0], TWO_ZERO};
            host_rd_data <= {TWO_ZERO, palette_hold_in[SIX_MSB:0]};
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    blank_gate_a: assert property (
        (blank && !extra_pend_reg && sc_state_reg == SC_LOW) |=> sc_state_reg != SC_HIGH)
        else $error("shift clock started during blanking");
    extra_pulse_a: assert property (
        (mode == FLAG_SPLIT && blank && flag_rise && sc_state_reg == SC_LOW)
        ##1 (blank && mode == FLAG_SPLIT) |=> sc_state_reg == SC_EXTRA)
        else $error("split flag rise gave no extra shift clock");
    flag_ignore_a: assert property (
        (mode == FLAG_IGNORE) |=> !$rose(extra_pend_reg))
        else $error("flag acted on while ignored");
    nib_sample_a: assert property (
        (mode == FLAG_NIBBLE && video_clock_out_fall) |=> nib_flag_reg == $past(flag_s2_reg))
        else $error("nibble flag not sampled at video clock fall");
    nib_upper_a: assert property (
        (push && mode == FLAG_NIBBLE && !passthrough_en && nib_flag_reg)
        ##1 (cnt_reg == CNT_ONE) |-> pix_out.upper_nib
        && pix_out.data[NIB_LO_MSB:0] == $past(pix_s2_reg[NIB_HI_MSB:NIB_HI_LSB]))
        else $error("upper nibble not captured");
    pass_byte_a: assert property (
        (push && passthrough_en) ##1 (cnt_reg == CNT_ONE) |->
        pix_out.passthru && pix_out.data == $past(pass_s2_reg))
        else $error("pass-through byte not captured whole");
    video_clock_out_toggle_a: assert property (
        video_clock_out_term |=> video_clock_out != $past(video_clock_out))
        else $error("video clock did not toggle");
    host_write_a: assert property (
        wr_rise |=> host_wr.strobe && host_wr.data == $past(hd_s2_reg))
        else $error("write data not captured at strobe rise");
    dac_six_a: assert property (
        !w8_s2_reg |=> dac_data == {$past(palette_dac_in[SIX_MSB:0]), TWO_ZERO})
        else $error("six-bit DAC shift wrong");
    rd_six_a: assert property (
        !w8_s2_reg |=> host_rd_data[BYTE_W-1:RD_HI_LSB] == TWO_ZERO)
        else $error("six-bit read top bits not zero");
    dac_full_a: assert property (
        w8_s2_reg |=> dac_data == $past(palette_dac_in))
        else $error("eight-bit DAC path altered");

    extra_seen_c: cover property (sc_state_reg == SC_EXTRA);
    nib_high_c: cover property (push && nib_flag_reg);
    buf_full_c: cover property (!buf_in_ready ##1 pop);
    host_wr_c: cover property (host_wr.strobe);
endmodule
`default_nettype wire

// ==== hw/pfhw_pkg.sv ====
// Shared constants and types for the pixel flag and host width control block
`default_nettype none
package pfhw_pkg;
    // General-control bit positions that pick the flag input's role
    localparam int GC_SPLIT_BIT = 2;
    localparam int GC_NIBBLE_BIT = 3;
    // Data widths and field positions
    localparam int BYTE_W = 8;
    localparam int DIV_W = 4;
    localparam int SIX_MSB = 5;
    localparam int NIB_HI_MSB = 7;
    localparam int NIB_HI_LSB = 4;
    localparam int NIB_LO_MSB = 3;
    localparam int FILL_MSB = 1;
    localparam int DAC_HI_LSB = 2;
    localparam int RD_HI_LSB = 6;
    // Fill values and reset values
    localparam logic [1:0] TWO_ZERO = 2'h0;
    localparam logic [3:0] NIB_PAD = 4'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] DIV_ZERO = 4'h0;
    // Depth of the pixel buffer
    localparam int PIX_BUF_DEPTH = 2;

    // Role of the dual-purpose flag input
    typedef enum logic [1:0] {
        FLAG_IGNORE,
        FLAG_SPLIT,
        FLAG_NIBBLE,
        FLAG_ILLEGAL
    } pfhw_flag_mode_t;

    // Shift clock generator states
    typedef enum logic [1:0] {
        SC_LOW,
        SC_HIGH,
        SC_EXTRA
    } pfhw_sc_state_t;

    // One captured pixel
    typedef struct packed {
        logic passthru;
        logic upper_nib;
        logic [BYTE_W-1:0] data;
    } pfhw_pixel_t;

    // One host register write
    typedef struct packed {
        logic strobe;
        logic [BYTE_W-1:0] data;
    } pfhw_host_wr_t;
endpackage
`default_nettype wire

// ==== hw/unused_placeholder_removed.sv ====
// Intentionally empty design file
`default_nettype none
`default_nettype wire

// ==== sim/pfhw_far_model.sv ====
// Far-side model: video memory shift register source and pixel sink
`default_nettype none
module pfhw_far_model #(
    parameter logic [7:0] START = 8'h03,
    parameter logic [7:0] STRIDE = 8'h10
) (
    input wire logic clk,
    input wire logic shift_clock_out,
    input wire pfhw_pkg::pfhw_pixel_t pix_out,
    input wire logic pix_valid,
    input wire logic stall,
    output logic [pfhw_pkg::BYTE_W-1:0] pixel_bus_in,
    output logic pix_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    import pfhw_pkg::*;
    // ****************************************
    // Source and sink
    // ****************************************
    logic [9:0] got_mem [0:255];
    int got_n = 0;
    int rises = 0;
    logic [7:0] shift_reg = START;
    // A stride of one upper nibble lets a check tell high and low nibbles apart
    assign pixel_bus_in = shift_reg;
    assign pix_ready = ~stall;
    // Shift register advances on every shift clock rise, extra pulses included
    always @(posedge shift_clock_out) begin
        shift_reg <= shift_reg + STRIDE;
        rises <= rises + 1;
    end
    // Sink takes a word at the edge where valid and ready are both high
    always @(posedge clk) begin
        if (pix_valid && pix_ready) begin
            got_mem[got_n % 256] <= pix_out;
            got_n <= got_n + 1;
        end
    end
endmodule
`default_nettype wire

// ==== sim/pfhw_ctrl_tb.sv ====
// Self-checking bench for the pixel flag and host width control block
`default_nettype none
module pfhw_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pfhw_pkg::*;
    // ****************************************
    // Stimulus, instances and checks
    // ****************************************
    localparam int CEIL = 6000;
    logic clk = 1'b0, reset = 1'b1, blank = 1'b1, passthrough_en = 1'b0, flag = 1'b0;
    logic host_wr_n = 1'b1, width8_sel = 1'b1, stall = 1'b1;
    logic [7:0] gen_ctrl = 8'h00, pass_bus = 8'h5a, host_data_in = 8'h00;
    logic [7:0] pal_hold = 8'h00, pal_dac = 8'h00, pixel_bus_in, host_rd_data, dac_data, sd, v;
    logic [7:0] ed, eh;
    logic [3:0] video_clock_out_div = 4'h2, sclk_div = 4'h1;
    logic video_clock_out, shift_clock_out, pix_valid, pix_ready;
    pfhw_host_wr_t host_wr;
    pfhw_pixel_t pix_out;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int nstb, per, base, r0, nr, hi;
    logic [7:0] vals [4] = '{8'hff, 8'ha5, 8'h3c, 8'h81};
    // Both control bits high is never applied
    logic [7:0] sp_gc [4] = '{8'h04, 8'h04, 8'h00, 8'h08};
    logic sp_fl [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    int sp_n [4] = '{1, 0, 0, 0};

    pfhw_ctrl #(.DEPTH(2)) i_dut (
        .clk(clk), .reset(reset), .gen_ctrl(gen_ctrl), .blank(blank),
        .passthrough_en(passthrough_en), .video_clock_out_div(video_clock_out_div), .sclk_div(sclk_div),
        .split_or_nibble_flag_in(flag), .pixel_bus_in(pixel_bus_in),
        .passthrough_pixel_bus(pass_bus), .host_wr_n(host_wr_n), .host_data_in(host_data_in),
        .width8_sel(width8_sel), .palette_hold_in(pal_hold), .palette_dac_in(pal_dac),
        .pix_ready(pix_ready), .video_clock_out(video_clock_out),
        .shift_clock_out(shift_clock_out), .host_wr(host_wr), .host_rd_data(host_rd_data),
        .dac_data(dac_data), .pix_out(pix_out), .pix_valid(pix_valid)
    );
    pfhw_far_model i_far (
        .clk(clk), .shift_clock_out(shift_clock_out), .pix_out(pix_out),
        .pix_valid(pix_valid), .stall(stall), .pixel_bus_in(pixel_bus_in), .pix_ready(pix_ready)
    );

    // Free-running 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    // Hang guard: a run that overstays its budget fails
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == CEIL) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chkv(input string what, input logic [9:0] exp, input logic [9:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkn(input string what, input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            n_errors++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Strobe low four cycles; data held well past the rising edge
    task automatic host_write(input logic [7:0] d, output int ns, output logic [7:0] seen);
        ns = 0;
        seen = 8'h00;
        host_data_in = d;
        tick(3);
        host_wr_n = 1'b0;
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            if (k == 3) host_wr_n = 1'b1;
            if (host_wr.strobe === 1'b1) begin
                ns++;
                seen = host_wr.data;
            end
        end
    endtask
    // Skips the first period after a divider change, which may run long
    task automatic clk_period(output int p);
        int t[$];
        logic last;
        int n;
        last = video_clock_out;
        n = 0;
        while (t.size() < 3 && n < 200) begin
            @(negedge clk);
            n++;
            if (video_clock_out === 1'b1 && last === 1'b0) t.push_back(n);
            last = video_clock_out;
        end
        p = (t.size() == 3) ? t[2] - t[1] : -1;
    endtask
    // Stream and upper-nibble words are predicted from the one before; other kinds expect a fixed word
    task automatic chk_words(input int from, input int kind);
        logic [9:0] w, prv, e;
        chkn("word count ok", 1, (i_far.got_n - from >= 3) ? 1 : 0);
        for (int k = from + 1; k < i_far.got_n; k++) begin
            prv = i_far.got_mem[(k - 1) % 256];
            w = i_far.got_mem[k % 256];
            case (kind)
                0: e = {2'b00, prv[7:0] + 8'h10};
                1: e = {2'b01, 4'h0, prv[3:0] + 4'h1};
                2: e = {2'b00, 8'h03};
                default: e = {2'b10, 8'h5a};
            endcase
            chkv("pixel word", e, w);
        end
    endtask
    task automatic split_try(input logic [7:0] gc, input logic pulse, output int n, output int h);
        int r;
        gen_ctrl = gc;
        tick(10);
        r = i_far.rises;
        h = 0;
        flag = pulse;
        for (int k = 0; k < 20; k++) begin
            @(negedge clk);
            if (shift_clock_out === 1'b1) h++;
        end
        flag = 1'b0;
        tick(5);
        n = i_far.rises - r;
    endtask

    // Main sequence
    initial begin
        tick(20);
        chkv("reset clocks", 10'h000, {8'h00, video_clock_out, shift_clock_out});
        chkv("reset outputs", 10'h000, {8'h00, host_wr.strobe, pix_valid});
        chkv("reset dac", 10'h000, {2'b00, dac_data});
        chkv("reset read", 10'h000, {2'b00, host_rd_data});
        reset = 1'b0;
        for (int w = 1; w >= 0; w--) begin
            width8_sel = w[0];
            for (int k = 0; k < 4; k++) begin
                v = vals[k];
                pal_dac = v;
                pal_hold = ~v;
                ed = w[0] ? v : {v[5:0], 2'b00};
                eh = w[0] ? ~v : {2'b00, ~v[5:0]};
                tick(4);
                chkv("dac data", {2'b00, ed}, {2'b00, dac_data});
                chkv("hold read", {2'b00, eh}, {2'b00, host_rd_data});
            end
        end
        $display("test width done");
        width8_sel = 1'b1;
        host_write(8'h96, nstb, sd);
        chkn("write strobes", 1, nstb);
        chkv("write data", 10'h096, {2'b00, sd});
        width8_sel = 1'b0;
        host_write(8'hff, nstb, sd);
        chkn("write strobes", 1, nstb);
        chkv("write data", 10'h0ff, {2'b00, sd});
        $display("test host write done");
        for (int d = 0; d < 6; d += 2) begin
            video_clock_out_div = d[3:0];
            clk_period(per);
            chkn("video clock period", 2 * (d + 1), per);
        end
        video_clock_out_div = 4'h2;
        $display("test video clock done");
        stall = 1'b0;
        blank = 1'b0;
        tick(20);
        base = i_far.got_n;
        for (int k = 0; k < 60; k++) begin
            @(negedge clk);
            flag = ~flag;
            if (k == 20) stall = 1'b1;
            if (k == 40) r0 = i_far.rises;
        end
        chkn("rises while full", 0, i_far.rises - r0);
        chkv("valid while full", 10'h001, {9'h000, pix_valid});
        stall = 1'b0;
        tick(40);
        chk_words(base, 0);
        $display("test stream done");
        passthrough_en = 1'b1;
        tick(20);
        base = i_far.got_n;
        tick(40);
        chk_words(base, 3);
        passthrough_en = 1'b0;
        gen_ctrl = 8'h08;
        for (int f = 1; f >= 0; f--) begin
            flag = f[0];
            tick(30);
            base = i_far.got_n;
            tick(60);
            chk_words(base, 2 - f);
        end
        $display("test pixel source done");
        blank = 1'b1;
        for (int k = 0; k < 4; k++) begin
            split_try(sp_gc[k], sp_fl[k], nr, hi);
            chkn("extra rises", sp_n[k], nr);
            chkn("extra high", (sclk_div + 1) * sp_n[k], hi);
        end
        chkv("drained", 10'h000, {9'h000, pix_valid});
        $display("test split done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
